/* logic/acb_pkg.sv */
// constants shared by the converter configuration register bank
package acb_pkg;
  localparam int NREG = 15;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 8;
  localparam int SAMPLE_W = 12;
  localparam int RAMP_DIV = 4;

  // register indices into the bank
  localparam int IDX_CTRL = 0;
  localparam int IDX_SWING = 1;
  localparam int IDX_PERF1 = 2;
  localparam int IDX_GAIN = 3;
  localparam int IDX_DRV = 4;
  localparam int IDX_FMT = 5;
  localparam int IDX_UHI = 6;
  localparam int IDX_ULO = 7;
  localparam int IDX_IFC = 8;
  localparam int IDX_FALL = 9;
  localparam int IDX_PDN = 10;
  localparam int IDX_PERF2 = 11;
  localparam int IDX_PED = 12;
  localparam int IDX_OCL = 13;
  localparam int IDX_RATE = 14;

  // byte addresses, writable masks, fixed-one bits and reset values, index 0 rightmost
  localparam logic [NREG-1:0][7:0] REG_OFFS = {8'hDF, 8'hCF, 8'hBF, 8'h4A, 8'h43, 8'h42, 8'h41, 8'h40,
                                               8'h3F, 8'h3D, 8'h26, 8'h25, 8'h03, 8'h01, 8'h00};
  localparam logic [NREG-1:0][7:0] REG_MASK = {8'h30, 8'hBC, 8'hF0, 8'h01, 8'h53, 8'hC4, 8'hFF, 8'hFC,
                                               8'h3F, 8'hE0, 8'h03, 8'hF7, 8'h03, 8'hFC, 8'h01};
  localparam logic [NREG-1:0][7:0] REG_FIXED = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00,
                                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [NREG-1:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00,
                                                8'h00, 8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 8'h00};

  // field positions
  localparam int BIT_READOUT = 0;
  localparam int BIT_SOFT_RESET = 1;
  localparam int BIT_DATA_DOUBLE = 0;
  localparam int BIT_CLK_DOUBLE = 1;
  localparam int BIT_OFFSET_EN = 5;
  localparam int BIT_STANDBY = 2;
  localparam int BIT_DRIVER_OFF = 4;
  localparam int BIT_GLOBAL_PDN = 6;

  localparam logic [1:0] SWING_ON = 2'h3;
  localparam logic [1:0] FMT_PIN = 2'h0;
  localparam logic [1:0] FMT_TWOS = 2'h2;
  localparam logic [1:0] FMT_OFFSET = 2'h3;

  localparam logic [SAMPLE_W-1:0] TOGGLE_A = 12'h555;
  localparam logic [SAMPLE_W-1:0] TOGGLE_B = 12'hAAA;

  typedef enum logic [2:0] {
    CHK_NORMAL = 3'h0,
    CHK_ZEROS = 3'h1,
    CHK_ONES = 3'h2,
    CHK_TOGGLE = 3'h3,
    CHK_RAMP = 3'h4,
    CHK_USER = 3'h5,
    CHK_UNUSED6 = 3'h6,
    CHK_UNUSED7 = 3'h7
  } acb_check_type;
endpackage

/* logic/acb_regbank.sv */
// converter configuration register bank with readback and output check patterns
`timescale 1ns/1ps
module acb_regbank #(
  parameter int DATA_W = acb_pkg::SAMPLE_W,
  parameter int BUF_DEPTH = 2
) (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CE,
  // serial configuration pins
  input wire logic SEN_N,
  input wire logic SCLK,
  input wire logic SDATA,
  input wire logic RESET_PIN,
  // converter side
  input wire logic SAMPLE_CLK,
  input wire logic [DATA_W-1:0] ADC_DATA,
  input wire logic OVERRANGE_IN,
  input wire logic FORMAT_INTERFACE_PIN,
  // shared over-range / readback pin
  output logic OVERRANGE_OR_SERIAL_OUT_PIN,
  // output word stream
  output logic [DATA_W-1:0] DATA_OUT,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  // configuration to the analog and driver blocks
  output logic [5:0] SWING_CODE,
  output logic [1:0] PERFORMANCE_BOOST_FIRST,
  output logic PERFORMANCE_BOOST_SECOND,
  output logic [3:0] GAIN_CODE,
  output logic CLOCK_DRIVER_DOUBLE,
  output logic DATA_DRIVER_DOUBLE,
  output logic TWOS_COMPLEMENT,
  output logic OFFSET_LOOP_EN,
  output logic STANDBY,
  output logic GLOBAL_POWER_DOWN,
  output logic DATA_OE_N,
  output logic CLK_OE_N
);
  localparam int NREG = acb_pkg::NREG;
  // pointers wrap naturally, so the depth must be a power of two
  localparam int PW = $clog2(BUF_DEPTH);

  // readback sequencer, gray coded along idle, address, data
  typedef enum logic [1:0] {
    RB_IDLE = 2'b00,
    RB_ADDR = 2'b01,
    RB_DATA = 2'b11
  } acb_rb_type;

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    acb_rb_type rb;
    logic [7:0] rd_sh;
    logic rd_first;
    logic [DATA_W-1:0] adc_s1;
    logic [DATA_W-1:0] adc_s2;
    logic [1:0] ovr_s;
    logic [1:0] fmt_s;
    logic [1:0] rst_s;
    logic [1:0] smp_s;
    logic smp_prev;
    logic [DATA_W-1:0] ramp;
    logic [1:0] div;
    logic tog;
    logic [BUF_DEPTH-1:0][DATA_W-1:0] fifo;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic twos;
  } acb_state_type;

  acb_state_type s_q, s_d;
  acb_ser_if ser ();

  acb_serial_rx u_rx (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .ce(CE),
    .sen_n(SEN_N),
    .sclk(SCLK),
    .sdata(SDATA),
    .ser(ser)
  );

  logic readout;
  logic smp_edge;
  logic push;
  logic pop;
  logic in_ready;
  logic [7:0] rd_byte;
  logic [DATA_W-1:0] user_word;
  logic [DATA_W-1:0] conv_word;
  logic [DATA_W-1:0] word;
  logic [NREG-1:0] hit;
  logic [NREG-1:0] wr_sel;
  logic [NREG-1:0][7:0] wr_val;
  logic soft_reset;
  logic hard_reset;
  logic swing_on;
  logic buf_full;
  logic [2:0] check_sel;
  logic [1:0] fmt_field;

  // address decode and write value, one per mapped register
  for (genvar gi = 0; gi < NREG; gi++) begin : g_dec
    assign hit[gi] = (ser.addr == acb_pkg::REG_OFFS[gi]);
    // reserved bits are dropped and fixed-one bits forced, whatever the controller sent
    assign wr_val[gi] = (ser.data & acb_pkg::REG_MASK[gi]) | acb_pkg::REG_FIXED[gi];
    // while readback is on only the control register accepts writes
    if (gi == acb_pkg::IDX_CTRL) begin : g_ctrl
      assign wr_sel[gi] = ser.word_valid & hit[gi];
    end else begin : g_other
      assign wr_sel[gi] = ser.word_valid & hit[gi] & ~readout;
    end
  end

  assign readout = s_q.regs[acb_pkg::IDX_CTRL][acb_pkg::BIT_READOUT];
  assign soft_reset = wr_sel[acb_pkg::IDX_CTRL] & ser.data[acb_pkg::BIT_SOFT_RESET];
  assign hard_reset = s_q.rst_s[1];
  assign smp_edge = s_q.smp_s[1] & ~s_q.smp_prev;
  assign check_sel = s_q.regs[acb_pkg::IDX_GAIN][2:0];
  assign fmt_field = s_q.regs[acb_pkg::IDX_FMT][7:6];
  assign user_word = DATA_W'({s_q.regs[acb_pkg::IDX_UHI][5:0], s_q.regs[acb_pkg::IDX_ULO][7:2]});

  assign buf_full = (s_q.count == (PW + 1)'(BUF_DEPTH));
  // a full buffer still takes the new word when a ready receiver frees a slot in the same cycle
  assign in_ready = ~buf_full | OUT_READY;
  assign push = smp_edge & in_ready;
  assign pop = (s_q.count != '0) & OUT_READY;

  // register zero cannot be read back and answers zero
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 1; i < NREG; i++) begin
      if (hit[i]) begin
        rd_byte = s_q.regs[i];
      end
    end
  end

  // the converter core delivers offset binary; twos complement flips the top bit
  always_comb begin
    conv_word = s_q.adc_s2;
    if (s_q.twos) begin
      conv_word[DATA_W-1] = ~s_q.adc_s2[DATA_W-1];
    end
  end

  always_comb begin
    unique case (acb_pkg::acb_check_type'(check_sel))
      acb_pkg::CHK_NORMAL: begin
        word = conv_word;
      end
      acb_pkg::CHK_ZEROS: begin
        word = '0;
      end
      acb_pkg::CHK_ONES: begin
        word = '1;
      end
      acb_pkg::CHK_TOGGLE: begin
        word = s_q.tog ? DATA_W'(acb_pkg::TOGGLE_B) : DATA_W'(acb_pkg::TOGGLE_A);
      end
      acb_pkg::CHK_RAMP: begin
        word = s_q.ramp;
      end
      acb_pkg::CHK_USER: begin
        word = user_word;
      end
      acb_pkg::CHK_UNUSED6, acb_pkg::CHK_UNUSED7: begin
        word = conv_word;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    // pins from outside the core clock domain pass two flip-flops
    s_d.ovr_s = {s_q.ovr_s[0], OVERRANGE_IN};
    s_d.fmt_s = {s_q.fmt_s[0], FORMAT_INTERFACE_PIN};
    s_d.rst_s = {s_q.rst_s[0], RESET_PIN};
    s_d.smp_s = {s_q.smp_s[0], SAMPLE_CLK};
    s_d.smp_prev = s_q.smp_s[1];
    // the converter word stands a whole sample period and is read only after the
    // synchronised sample edge, so a plain two-stage copy cannot tear it
    s_d.adc_s1 = ADC_DATA;
    s_d.adc_s2 = s_q.adc_s1;

    // every field of the addressed register is taken from the one word
    for (int i = 0; i < NREG; i++) begin
      if (wr_sel[i]) begin
        s_d.regs[i] = wr_val[i];
      end
    end
    // the reset bit is outside the writable mask, so it always reads back as zero
    if (soft_reset || hard_reset) begin
      s_d.regs = acb_pkg::REG_RESET;
    end

    // readback: load at the end of the address, show the top bit for the first
    // data rise, then move one bit on every later rise so it is sampled while high
    unique case (s_q.rb)
      RB_IDLE: begin
        if (ser.active && readout) begin
          s_d.rb = RB_ADDR;
        end
      end
      RB_ADDR: begin
        if (!ser.active) begin
          s_d.rb = RB_IDLE;
        end else if (ser.addr_done) begin
          s_d.rb = RB_DATA;
          s_d.rd_sh = rd_byte;
          s_d.rd_first = 1'b1;
        end
      end
      RB_DATA: begin
        if (!ser.active) begin
          s_d.rb = RB_IDLE;
        end else if (ser.word_valid) begin
          // further words within one enable pulse are read the same way
          s_d.rb = RB_ADDR;
        end else if (ser.sclk_rise) begin
          if (s_q.rd_first) begin
            s_d.rd_first = 1'b0;
          end else begin
            s_d.rd_sh = {s_q.rd_sh[6:0], 1'b0};
          end
        end
      end
      default: begin
        s_d.rb = RB_IDLE;
      end
    endcase

    // pattern generators step on the synchronised sample clock edge
    if (smp_edge) begin
      s_d.tog = ~s_q.tog;
      if (check_sel == 3'(acb_pkg::CHK_RAMP)) begin
        s_d.div = s_q.div + 2'h1;
        if (s_q.div == 2'(acb_pkg::RAMP_DIV - 1)) begin
          // wraps from 4095 back to zero
          s_d.ramp = s_q.ramp + DATA_W'(1);
        end
      end else begin
        // leaving ramp mode restarts the ramp from code zero
        s_d.div = 2'h0;
        s_d.ramp = '0;
      end
    end

    unique case (fmt_field)
      acb_pkg::FMT_TWOS: begin
        s_d.twos = 1'b1;
      end
      acb_pkg::FMT_OFFSET: begin
        s_d.twos = 1'b0;
      end
      default: begin
        // a low format pin selects twos complement; 01 is not a legal code
        s_d.twos = ~s_q.fmt_s[1];
      end
    endcase

    // two-entry buffer: a word that finds it full while the receiver is stalled is lost, the converter cannot stall
    if (push) begin
      s_d.fifo[s_q.wr_ptr] = word;
      s_d.wr_ptr = s_q.wr_ptr + PW'(1);
    end
    if (pop) begin
      s_d.rd_ptr = s_q.rd_ptr + PW'(1);
    end
    unique case ({push, pop})
      2'b10: s_d.count = s_q.count + (PW + 1)'(1);
      2'b01: s_d.count = s_q.count - (PW + 1)'(1);
      2'b00, 2'b11: s_d.count = s_q.count;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '{
        regs: acb_pkg::REG_RESET,
        rb: RB_IDLE,
        twos: 1'b1,
        default: '0
      };
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // output word stream
  assign OUT_VALID = (s_q.count != '0);
  assign DATA_OUT = s_q.fifo[s_q.rd_ptr];

  // shared pin
  assign OVERRANGE_OR_SERIAL_OUT_PIN = readout ? s_q.rd_sh[7] : s_q.ovr_s[1];

  // amplitude and performance
  assign swing_on = (s_q.regs[acb_pkg::IDX_PDN][1:0] == acb_pkg::SWING_ON);
  assign SWING_CODE = swing_on ? s_q.regs[acb_pkg::IDX_SWING][7:2] : 6'h00;
  assign PERFORMANCE_BOOST_FIRST = s_q.regs[acb_pkg::IDX_PERF1][1:0];
  assign PERFORMANCE_BOOST_SECOND = s_q.regs[acb_pkg::IDX_PERF2][0];
  // forbidden gain codes are passed on unchanged
  assign GAIN_CODE = s_q.regs[acb_pkg::IDX_GAIN][7:4];

  // drivers and format
  assign CLOCK_DRIVER_DOUBLE = s_q.regs[acb_pkg::IDX_DRV][acb_pkg::BIT_CLK_DOUBLE];
  assign DATA_DRIVER_DOUBLE = s_q.regs[acb_pkg::IDX_DRV][acb_pkg::BIT_DATA_DOUBLE];
  assign TWOS_COMPLEMENT = s_q.twos;
  assign OFFSET_LOOP_EN = s_q.regs[acb_pkg::IDX_FMT][acb_pkg::BIT_OFFSET_EN];

  // power control; output enables are low while the drivers run
  assign STANDBY = s_q.regs[acb_pkg::IDX_FALL][acb_pkg::BIT_STANDBY];
  assign GLOBAL_POWER_DOWN = s_q.regs[acb_pkg::IDX_PDN][acb_pkg::BIT_GLOBAL_PDN];
  assign DATA_OE_N = s_q.regs[acb_pkg::IDX_PDN][acb_pkg::BIT_DRIVER_OFF];
  assign CLK_OE_N = s_q.regs[acb_pkg::IDX_PDN][acb_pkg::BIT_DRIVER_OFF];
endmodule

/* logic/acb_ser_if.sv */
// carrier between the serial receiver and the register bank
`timescale 1ns/1ps
interface acb_ser_if;
  logic word_valid;
  logic addr_done;
  logic sclk_rise;
  logic active;
  logic [7:0] addr;
  logic [7:0] data;
  modport rx (output word_valid, output addr_done, output sclk_rise, output active, output addr, output data);
  modport bank (input word_valid, input addr_done, input sclk_rise, input active, input addr, input data);
endinterface

/* logic/acb_serial_rx.sv */
// three-wire serial write receiver, oversampled on the core clock
`timescale 1ns/1ps
module acb_serial_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // serial pins
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic sdata,
  // decoded words
  acb_ser_if.rx ser
);
  typedef struct packed {
    logic [1:0] sen_s;
    logic [1:0] sclk_s;
    logic [1:0] sda_s;
    logic sclk_prev;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic word_valid;
    logic addr_done;
    logic sclk_rise;
  } acb_rx_type;

  acb_rx_type s_q, s_d;
  logic fall;
  logic rise;
  logic [15:0] sh_next;

  assign fall = s_q.sclk_prev & ~s_q.sclk_s[1];
  assign rise = ~s_q.sclk_prev & s_q.sclk_s[1];
  assign sh_next = {s_q.sh[14:0], s_q.sda_s[1]};

  always_comb begin
    s_d = s_q;
    s_d.sen_s = {s_q.sen_s[0], sen_n};
    s_d.sclk_s = {s_q.sclk_s[0], sclk};
    s_d.sda_s = {s_q.sda_s[0], sdata};
    s_d.sclk_prev = s_q.sclk_s[1];
    s_d.word_valid = 1'b0;
    s_d.addr_done = 1'b0;
    s_d.sclk_rise = rise & ~s_q.sen_s[1];
    if (s_q.sen_s[1]) begin
      // a partial word is dropped when the enable goes high
      s_d.cnt = 4'h0;
    end else if (fall) begin
      s_d.sh = sh_next;
      s_d.cnt = s_q.cnt + 4'h1;
      s_d.addr_done = (s_q.cnt == 4'(acb_pkg::ADDR_BITS - 1));
      s_d.word_valid = (s_q.cnt == 4'(acb_pkg::WORD_BITS - 1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{sen_s: 2'h3, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign ser.word_valid = s_q.word_valid;
  assign ser.addr_done = s_q.addr_done;
  assign ser.sclk_rise = s_q.sclk_rise;
  assign ser.active = ~s_q.sen_s[1];
  assign ser.addr = ser.word_valid ? s_q.sh[15:8] : s_q.sh[7:0];
  assign ser.data = s_q.sh[7:0];
endmodule

/* sim/acb_ctrl_model.sv */
// serial controller that writes words and samples the shared pin
`timescale 1ns/1ps
module acb_ctrl_model #(parameter int HALF = 8) (
  // clock
  input wire logic clk,
  // serial pins
  output logic sen_n,
  output logic sclk,
  output logic sdata,
  input wire logic sdout
);
  initial begin
    sen_n = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
  end
  // address first, msb first; clock idles low between frames
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    @(posedge clk) sen_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (HALF) @(posedge clk);
      sdata <= w[i];
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      if (i < 8) rd[i] = sdout;
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    sen_n <= 1'b1;
    sdata <= ~w[0];
  endtask
endmodule

/* sim/acb_regbank_assertions.sv */
// assertions on the configuration bank ports
`timescale 1ns/1ps
module acb_regbank_assertions #(parameter int DATA_W = 12) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // watched ports
  input wire logic SEN_N,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire logic [DATA_W-1:0] DATA_OUT,
  input wire logic [5:0] SWING_CODE,
  input wire logic [3:0] GAIN_CODE,
  input wire logic DATA_OE_N,
  input wire logic CLK_OE_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // cycles since the enable was low: settings may only move close to a frame
  logic [7:0] idle_q;
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN) idle_q <= 8'hFF;
    else if (!SEN_N) idle_q <= 8'h00;
    else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
  property p_rst_gain; $rose(RESETN) |-> GAIN_CODE == 4'h5; endproperty
  a_rst_gain: assert property (p_rst_gain) else $error("gain reset");
  property p_rst_out; $rose(RESETN) |-> SWING_CODE == 6'h00 && !DATA_OE_N; endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outputs");
  property p_oe_pair; DATA_OE_N == CLK_OE_N; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  property p_hold_v; OUT_VALID && !OUT_READY |=> OUT_VALID; endproperty
  a_hold_v: assert property (p_hold_v) else $error("valid dropped");
  property p_hold_d; OUT_VALID && !OUT_READY |=> $stable(DATA_OUT); endproperty
  a_hold_d: assert property (p_hold_d) else $error("data moved");
  property p_gain_q; $changed(GAIN_CODE) |-> idle_q < 8'd40; endproperty
  a_gain_q: assert property (p_gain_q) else $error("gain moved");
  property p_swing_q; $changed(SWING_CODE) |-> idle_q < 8'd40; endproperty
  a_swing_q: assert property (p_swing_q) else $error("swing moved");
  property p_oe_q; $changed(DATA_OE_N) |-> idle_q < 8'd40; endproperty
  a_oe_q: assert property (p_oe_q) else $error("enable moved");
endmodule
bind acb_regbank acb_regbank_assertions #(.DATA_W(DATA_W)) u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .SEN_N(SEN_N), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .DATA_OUT(DATA_OUT), .SWING_CODE(SWING_CODE),
  .GAIN_CODE(GAIN_CODE), .DATA_OE_N(DATA_OE_N), .CLK_OE_N(CLK_OE_N));

/* sim/test_acb_regbank.sv */
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module test_acb_regbank;
  logic clk, rstn, sclk, sen_n, sdata, smp, ovr, rdy, valid, pin, cdd, ddd, twos, doe_n, coe_n;
  logic perf2, ole, stby, gpd;
  logic [1:0] perf1;
  logic [11:0] dout, w, v;
  logic [7:0] rd;
  logic [5:0] swing;
  logic [3:0] gain;
  logic [2:0] pat [3] = '{3'h1, 3'h2, 3'h5};
  logic [11:0] pexp [3] = '{12'h000, 12'hFFF, 12'hAAD};
  int n_errors = 0, compares = 0;
  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  initial begin smp = 1'b0; forever #8 smp = ~smp; end
  acb_regbank dut (.CORE_CLK(clk), .RESETN(rstn), .CE(1'b1), .SEN_N(sen_n), .SCLK(sclk), .SDATA(sdata),
    .RESET_PIN(1'b0), .SAMPLE_CLK(smp), .ADC_DATA(12'h3C5), .OVERRANGE_IN(ovr), .FORMAT_INTERFACE_PIN(1'b0),
    .OVERRANGE_OR_SERIAL_OUT_PIN(pin), .DATA_OUT(dout), .OUT_VALID(valid), .OUT_READY(rdy), .SWING_CODE(swing),
    .PERFORMANCE_BOOST_FIRST(perf1), .PERFORMANCE_BOOST_SECOND(perf2), .GAIN_CODE(gain),
    .CLOCK_DRIVER_DOUBLE(cdd), .DATA_DRIVER_DOUBLE(ddd), .TWOS_COMPLEMENT(twos), .OFFSET_LOOP_EN(ole),
    .STANDBY(stby), .GLOBAL_POWER_DOWN(gpd),
    .DATA_OE_N(doe_n), .CLK_OE_N(coe_n));
  acb_ctrl_model ctrl (.clk(clk), .sen_n(sen_n), .sclk(sclk), .sdata(sdata), .sdout(pin));
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ctrl.xfer({a, d}, rd);
    repeat (8) @(posedge clk);
  endtask
  // n successive accepted words; stale words from before a change are skipped by the caller
  task automatic get(input int n, output logic [11:0] g);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      @(posedge clk);
      while (!(valid === 1'b1 && rdy === 1'b1) && t < 200) begin
        @(posedge clk);
        t++;
      end
      if (t >= 200) begin
        n_errors++;
        results();
      end
      g = dout;
    end
  endtask
  initial begin
    rstn = 1'b0;
    rdy = 1'b1;
    ovr = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("gain", 12'h5, 12'(gain));
    chk("pin", 12'h1, 12'(pin));
    $display("test reset done");
    wr(8'h3F, 8'h2A);
    wr(8'h40, 8'hB4);
    foreach (pat[i]) begin
      wr(8'h25, {4'hC, 1'b0, pat[i]});
      get(4, w);
      chk("pattern", pexp[i], w);
    end
    wr(8'h25, 8'hC4);
    get(4, w);
    get(8, v);
    chk("ramp", 12'h2, v - w);
    wr(8'h25, 8'hC3);
    get(4, w);
    rdy <= 1'b0;
    repeat (20) @(posedge clk);
    rdy <= 1'b1;
    get(1, v);
    chk("toggle", 12'hFFF, w ^ v);
    chk("gain", 12'hC, 12'(gain));
    $display("capture_check_select done");
    wr(8'h01, 8'hF8);
    chk("swing off", 12'h0, 12'(swing));
    wr(8'h43, 8'h03);
    chk("swing", 12'h3E, 12'(swing));
    wr(8'h26, 8'h03);
    chk("drive", 12'h3, 12'({cdd, ddd}));
    wr(8'h3D, 8'hC0);
    chk("offset bin", 12'h0, 12'(twos));
    wr(8'h3D, 8'hA0);
    chk("twos", 12'h3, 12'({twos, ole}));
    wr(8'h03, 8'h03);
    wr(8'h4A, 8'h01);
    wr(8'h42, 8'h0C);
    chk("boost", 12'h7, 12'({perf1, perf2}));
    chk("standby", 12'h1, 12'(stby));
    wr(8'h43, 8'h53);
    chk("oe", 12'h7, 12'({gpd, doe_n, coe_n}));
    wr(8'h00, 8'h02);
    chk("soft reset", 12'h500, {gain, swing, doe_n, coe_n});
    // after reset the format follows the low pin: twos complement of the core word
    get(4, w);
    chk("normal", 12'hBC5, w);
    $display("test config done");
    wr(8'h00, 8'h01);
    ctrl.xfer(16'h2500, rd);
    chk("readback", 12'h50, 12'(rd));
    wr(8'h00, 8'h00);
    $display("test readout done");
    results();
  end
endmodule
